// *** logic/sdmac_pkg.sv ***
package sdmac_pkg;
    // ==========================================================
    // Register map
    localparam logic [11:0] SDMAC_DMA_SETUP_ADDR = 12'h0330;
    localparam logic [11:0] SDMAC_AREA_FILLED_ADDR = 12'h0334;
    localparam logic [31:0] SDMAC_RESET_VALUE = 32'h0000_0000;
    // ==========================================================
    // Field positions of dma_setup
    localparam int SDMAC_DIR_BIT = 0;
    localparam int SDMAC_RUN_BIT = 1;
    localparam int SDMAC_BURST_LSB = 2;
    localparam int SDMAC_BURST_MSB = 3;
    localparam int SDMAC_COUNT_LSB = 8;
    localparam int SDMAC_COUNT_MSB = 31;
    localparam int SDMAC_COUNT_W = 24;
    // ==========================================================
    // Field positions of descriptor_area_filled
    localparam int SDMAC_ASYNC_BIT = 0;
    localparam int SDMAC_INTR_BIT = 1;
    localparam int SDMAC_ISO_BIT = 2;
    localparam int SDMAC_AREAS = 3;
    // ==========================================================
    // Burst size selector codes and beat counts
    localparam logic [1:0] SDMAC_BURST_SINGLE = 2'h0;
    localparam logic [1:0] SDMAC_BURST_4 = 2'h1;
    localparam logic [1:0] SDMAC_BURST_8 = 2'h2;
    localparam logic [4:0] SDMAC_BEATS_1 = 5'h01;
    localparam logic [4:0] SDMAC_BEATS_4 = 5'h04;
    localparam logic [4:0] SDMAC_BEATS_8 = 5'h08;
    localparam logic [4:0] SDMAC_BEATS_16 = 5'h10;
    // Bytes per word for each bus width setting
    localparam logic [SDMAC_COUNT_W-1:0] SDMAC_BYTES_16 = 24'h00_0002;
    localparam logic [SDMAC_COUNT_W-1:0] SDMAC_BYTES_32 = 24'h00_0004;
    // Host-side command port of the far end
    localparam logic [3:0] SDMAC_CMD_SETUP = 4'h0;
    localparam logic [3:0] SDMAC_CMD_AREA = 4'h4;
    localparam logic [3:0] SDMAC_CMD_STATUS = 4'h8;
    localparam logic [3:0] SDMAC_CMD_RDATA = 4'hC;
    // Device engine states
    typedef enum logic [1:0] {
        SDMAC_IDLE = 2'b00,
        SDMAC_BURST = 2'b01,
        SDMAC_DONE = 2'b10
    } sdmac_state_e;
endpackage

// *** logic/sdmac_if.sv ***
`timescale 1ns/1ps
// ==========================================================
// Register access and data stream between host side and device
interface sdmac_if;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic dreq;        // Device wants a burst
    logic [4:0] beats; // Words in a full burst, per the burst selector
    logic h2d_valid;
    logic h2d_ready;
    logic [31:0] h2d_data;
    logic d2h_valid;
    logic d2h_ready;
    logic [31:0] d2h_data;
    modport dev (input addr, wdata, wr, rd, h2d_valid, h2d_data, d2h_ready,
                 output rdata, dreq, beats, h2d_ready, d2h_valid, d2h_data);
    modport host (output addr, wdata, wr, rd, h2d_valid, h2d_data, d2h_ready,
                  input rdata, dreq, beats, h2d_ready, d2h_valid, d2h_data);
endinterface

// *** logic/sdmac_device.sv ***
`timescale 1ns/1ps
module sdmac_device import sdmac_pkg::*; #(
    parameter int DEPTH = 2
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic bus_32_i,
    input wire logic [SDMAC_AREAS-1:0] hdr_valid_i,
    input wire logic [SDMAC_AREAS-1:0] hdr_skip_i,
    input wire logic ram_ready_i,
    input wire logic [31:0] ram_rdata_i,
    sdmac_if.dev bus,
    output logic [SDMAC_AREAS-1:0] walk_area_o,
    output logic ram_we_o,
    output logic [31:0] ram_wdata_o,
    output logic ram_re_o,
    output logic busy_o
);
    // ==========================================================
    // Registers
    logic [31:0] dma_setup;
    logic [SDMAC_AREAS-1:0] area_filled;
    logic [SDMAC_COUNT_W-1:0] remaining;
    logic [4:0] beat_left;
    sdmac_state_e state;
    logic [31:0] fifo_q [DEPTH];
    logic [$clog2(DEPTH):0] fifo_cnt;
    logic [$clog2(DEPTH)-1:0] rd_ptr;
    logic [$clog2(DEPTH)-1:0] wr_ptr;

    // Decode
    wire sel_setup = bus.addr == SDMAC_DMA_SETUP_ADDR;
    wire sel_area = bus.addr == SDMAC_AREA_FILLED_ADDR;
    wire run = dma_setup[SDMAC_RUN_BIT];
    wire dir_rd = dma_setup[SDMAC_DIR_BIT];
    wire [1:0] bsel = dma_setup[SDMAC_BURST_MSB:SDMAC_BURST_LSB];
    // Byte step per word follows the bus width setting
    wire [SDMAC_COUNT_W-1:0] step = bus_32_i ? SDMAC_BYTES_32 : SDMAC_BYTES_16;
    wire [4:0] blen = (bsel == SDMAC_BURST_SINGLE) ? SDMAC_BEATS_1 :
                      (bsel == SDMAC_BURST_4) ? SDMAC_BEATS_4 :
                      (bsel == SDMAC_BURST_8) ? SDMAC_BEATS_8 : SDMAC_BEATS_16;
    wire fifo_full = fifo_cnt == ($clog2(DEPTH)+1)'(DEPTH);
    wire fifo_empty = fifo_cnt == '0;
    // One shared buffer serves both directions; the source differs
    wire in_burst = state == SDMAC_BURST;
    wire push_w = in_burst && !dir_rd && bus.h2d_valid && !fifo_full;
    wire push_r = in_burst && dir_rd && ram_ready_i && !fifo_full;
    wire push = push_w || push_r;
    wire pop_w = !dir_rd && !fifo_empty;
    wire pop_r = dir_rd && !fifo_empty && bus.d2h_ready;
    wire pop = pop_w || pop_r;
    wire [31:0] push_data = dir_rd ? ram_rdata_i : bus.h2d_data;
    // Last word of burst or of whole count ends the burst
    wire last_word = (beat_left == 5'h01) || (remaining <= step);
    wire [SDMAC_COUNT_W-1:0] next_remaining = (remaining <= step) ? '0 : remaining - step;
    // Area walk only where flag is set and header usable
    wire [SDMAC_AREAS-1:0] next_walk = area_filled & hdr_valid_i & ~hdr_skip_i;

    assign bus.h2d_ready = in_burst && !dir_rd && !fifo_full;
    assign bus.d2h_valid = dir_rd && !fifo_empty;
    assign bus.d2h_data = fifo_q[rd_ptr];
    assign bus.dreq = state == SDMAC_IDLE && run && remaining != '0;
    assign bus.beats = blen;

    // ==========================================================
    // Register writes; software clear of run terminates at once
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dma_setup <= SDMAC_RESET_VALUE;
            area_filled <= '0;
        end else if (clk_en_i) begin
            if (bus.wr && sel_setup) begin
                dma_setup <= bus.wdata;
            end else if (bus.wr && sel_area) begin
                area_filled <= bus.wdata[SDMAC_ISO_BIT:SDMAC_ASYNC_BIT];
            end
        end
    end

    // Read data one cycle after strobe; unmapped reads zero
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus.rdata <= '0;
        end else if (clk_en_i) begin
            if (bus.rd && sel_setup) begin
                bus.rdata <= {remaining, dma_setup[SDMAC_COUNT_LSB-1:0]};
            end else if (bus.rd && sel_area) begin
                bus.rdata <= {{(32-SDMAC_AREAS){1'b0}}, area_filled};
            end else begin
                bus.rdata <= '0;
            end
        end
    end

    // ==========================================================
    // Burst engine; count reloads on each write of the setup word
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= SDMAC_IDLE;
            remaining <= '0;
            beat_left <= '0;
        end else if (clk_en_i) begin
            if (bus.wr && sel_setup) begin
                remaining <= bus.wdata[SDMAC_COUNT_MSB:SDMAC_COUNT_LSB];
                state <= SDMAC_IDLE;
            end else if (!run) begin
                state <= SDMAC_IDLE;
            end else begin
                case (state)
                    SDMAC_IDLE: begin
                        if (remaining != '0) begin
                            state <= SDMAC_BURST;
                            beat_left <= blen;
                        end else begin
                            state <= SDMAC_DONE;
                        end
                    end
                    SDMAC_BURST: begin
                        if (push) begin
                            remaining <= next_remaining;
                            beat_left <= beat_left - 5'h01;
                            if (last_word) begin
                                state <= SDMAC_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= SDMAC_DONE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Two-entry buffer; a stalled consumer holds back the source
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fifo_cnt <= '0;
            rd_ptr <= '0;
            wr_ptr <= '0;
        end else if (clk_en_i) begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fifo_cnt <= fifo_cnt + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (clk_en_i && push) begin
            fifo_q[wr_ptr] <= push_data;
        end
    end

    // Registered side outputs
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            walk_area_o <= '0;
            ram_we_o <= 1'b0;
            ram_wdata_o <= '0;
            ram_re_o <= 1'b0;
            busy_o <= 1'b0;
        end else if (clk_en_i) begin
            walk_area_o <= next_walk;
            ram_we_o <= pop_w;
            ram_wdata_o <= fifo_q[rd_ptr];
            ram_re_o <= push_r;
            busy_o <= in_burst;
        end
    end
endmodule

// *** logic/sdmac_host.sv ***
`timescale 1ns/1ps
// ==========================================================
// Far end: turns command-port orders into register accesses and
// moves stream words for the device
module sdmac_host import sdmac_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic [3:0] cmd_addr_i,
    input wire logic [31:0] cmd_wdata_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_rd_i,
    input wire logic src_valid_i,
    input wire logic [31:0] src_data_i,
    sdmac_if.host bus,
    output logic [31:0] cmd_rdata_o,
    output logic src_ready_o,
    output logic [31:0] sink_data_o,
    output logic sink_valid_o
);
    logic rd_pend;
    logic [31:0] last_rx;

    // Reserved bits forced to zero on every write
    wire [31:0] setup_clean = cmd_wdata_i & 32'hFFFF_FF0F;
    wire [31:0] area_clean = cmd_wdata_i & 32'h0000_0007;
    wire is_setup = cmd_addr_i == SDMAC_CMD_SETUP;
    wire is_area = cmd_addr_i == SDMAC_CMD_AREA;
    wire is_status = cmd_addr_i == SDMAC_CMD_STATUS;

    // Burst field and width honoured by the device; host only forwards
    assign bus.h2d_valid = src_valid_i;
    assign bus.h2d_data = src_data_i;
    assign bus.d2h_ready = 1'b1;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus.addr <= '0;
            bus.wdata <= '0;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            rd_pend <= 1'b0;
        end else if (clk_en_i) begin
            bus.wr <= cmd_wr_i && (is_setup || is_area);
            bus.rd <= cmd_rd_i && (is_setup || is_area);
            rd_pend <= bus.rd;                          // Device answers one cycle after rd
            bus.addr <= is_area ? SDMAC_AREA_FILLED_ADDR : SDMAC_DMA_SETUP_ADDR;
            bus.wdata <= is_area ? area_clean : setup_clean;
        end
    end

    // Replies and stream outputs
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_rdata_o <= '0;
            src_ready_o <= 1'b0;
            sink_data_o <= '0;
            sink_valid_o <= 1'b0;
            last_rx <= '0;
        end else if (clk_en_i) begin
            src_ready_o <= bus.h2d_ready;
            sink_valid_o <= bus.d2h_valid;
            sink_data_o <= bus.d2h_data;
            if (bus.d2h_valid) begin
                last_rx <= bus.d2h_data;
            end
            if (rd_pend) begin
                cmd_rdata_o <= bus.rdata;
            end else if (cmd_rd_i && is_status) begin
                cmd_rdata_o <= {26'h000_0000, bus.beats, bus.dreq};
            end else if (cmd_rd_i && cmd_addr_i == SDMAC_CMD_RDATA) begin
                cmd_rdata_o <= last_rx;
            end
        end
    end
endmodule

// *** dv/sdmac_monitor.sv ***
`timescale 1ns/1ps
// ==========================================================
// Protocol checks on the interface between host and device
module sdmac_monitor (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic dreq,
    input wire logic [4:0] beats,
    input wire logic h2d_valid,
    input wire logic h2d_ready
);
    logic [31:0] setup_q;
    logic [2:0] area_q;
    logic [4:0] push_cnt;
    // Decodes; 01/10/11 map to 4/8/16 by one shift
    wire setup_wr = wr && (addr == 12'h330);
    wire area_wr = wr && (addr == 12'h334);
    wire [4:0] exp_beats = (setup_q[3:2] == 2'h0) ? 5'h01 : (5'h02 << setup_q[3:2]);
    wire push = h2d_valid && h2d_ready;
    default clocking mon_cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Shadow of the last writes; push count restarts whenever ready drops
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            setup_q <= 32'h0000_0000;
            area_q <= 3'h0;
            push_cnt <= 5'h00;
        end else begin
            if (setup_wr) setup_q <= wdata;
            if (area_wr) area_q <= wdata[2:0];
            push_cnt <= h2d_ready ? push_cnt + {4'h0, push} : 5'h00;
        end
    end
    // ==========================================================
    // Assertions
    AST_BEATS: assert property (dreq |-> beats == exp_beats)
        else $error("burst length differs from selector");
    AST_BURST_SIZE_SEL: assert property (push |-> push_cnt < beats)
        else $error("more words than burst length");
    AST_DREQ_RUN: assert property (dreq |-> setup_q[1])
        else $error("request while run bit clear");
    AST_H2D_DIR: assert property (h2d_ready |-> setup_q[1] && !setup_q[0])
        else $error("write stream open outside write direction");
    AST_START: assert property ($rose(dreq) && !setup_q[0] |-> ##[1:4] h2d_ready)
        else $error("burst did not open after request");
    AST_DREQ_ZERO: assert property (setup_wr && wdata[31:8] == 24'h0 |=> !dreq)
        else $error("request with zero byte count");
    AST_AREA_READ: assert property (rd && addr == 12'h334 |=> rdata == {29'h0, area_q})
        else $error("area flags read back wrong");
    AST_SETUP_LOW: assert property (rd && addr == 12'h330 |=> rdata[7:0] == setup_q[7:0])
        else $error("setup low byte read back wrong");
    AST_SETUP_HOLD: assert property (rd && addr == 12'h330 && !setup_q[1]
        |=> rdata[31:8] == setup_q[31:8])
        else $error("idle byte count read back wrong");
    COV_BURST16: cover property (dreq && beats == 5'h10);
    COV_FOURTH_PUSH: cover property (push && push_cnt == 5'h03);
    COV_AREA_READ: cover property (rd && addr == 12'h334);
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bench: host end and device end joined by the interface
module tb_top;
    localparam logic [31:0] WDAT = 32'hA5C3_1E0F;
    localparam logic [31:0] RDAT = 32'h5A3C_E1F0;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic bus_32, ram_ready, cmd_wr, cmd_rd, src_valid;
    logic ram_we, ram_re, busy, src_ready, sink_valid;
    logic [2:0] hdr_valid, hdr_skip, walk;
    logic [3:0] cmd_addr;
    logic [31:0] cmd_wdata, cmd_rdata, sink_data, ram_wdata;
    int err_count = 0;
    int compares = 0;
    int moved = 0;
    int fetched = 0;
    int cycles = 0;
    sdmac_if bus_if();
    sdmac_device i_sdmac_device (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
        .bus_32_i(bus_32), .hdr_valid_i(hdr_valid), .hdr_skip_i(hdr_skip),
        .ram_ready_i(ram_ready), .ram_rdata_i(RDAT), .bus(bus_if), .walk_area_o(walk),
        .ram_we_o(ram_we), .ram_wdata_o(ram_wdata), .ram_re_o(ram_re), .busy_o(busy));
    sdmac_host i_sdmac_host (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd),
        .src_valid_i(src_valid), .src_data_i(WDAT), .bus(bus_if), .cmd_rdata_o(cmd_rdata),
        .src_ready_o(src_ready), .sink_data_o(sink_data), .sink_valid_o(sink_valid));
    sdmac_monitor i_mon (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
        .dreq(bus_if.dreq), .beats(bus_if.beats), .h2d_valid(bus_if.h2d_valid),
        .h2d_ready(bus_if.h2d_ready));
    always #25 sys_clk_i = ~sys_clk_i;
    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("mismatches=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Payload of every moved word, sampled mid-cycle once outputs settle
    always @(negedge sys_clk_i) begin
        cycles++;
        if (ram_re) begin
            fetched++;
        end
        if (ram_we) begin
            moved++;
            chk(ram_wdata, WDAT);
        end
        if (sink_valid) begin
            moved++;
            chk(sink_data, RDAT);
        end
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    // ==========================================================
    // Command port access; read result is registered twice on its way
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge sys_clk_i);
        cmd_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge sys_clk_i);
        cmd_rd <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1 chk(cmd_rdata, exp);
    endtask
    // One programmed transfer; source and RAM stay willing past the end
    task automatic xfer(input logic b32, input logic [23:0] cnt, input logic [1:0] bl,
                        input logic dir, input logic run, input int words);
        int base;
        int fbase;
        base = moved;
        fbase = fetched;
        bus_32 <= b32;
        wr_reg(4'h0, {cnt, 4'h0, bl, run, dir});
        // Offer data only after the new setting has landed in the device
        @(posedge sys_clk_i);
        src_valid <= !dir;
        ram_ready <= dir;
        for (int k = 0; k < 400 && moved - base < words; k++) @(posedge sys_clk_i);
        repeat (20) @(posedge sys_clk_i);
        src_valid <= 1'b0;
        ram_ready <= 1'b0;
        chk(32'(moved - base), 32'(words));
        chk(32'(fetched - fbase), dir ? 32'(words) : 32'h0000_0000);
        chk(32'({busy, src_ready}), 32'h0000_0000);
        rd_chk(4'h0, {(run ? 24'h0 : cnt), 4'h0, bl, run, dir});
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {bus_32, ram_ready, cmd_wr, cmd_rd, src_valid} = 5'h00;
        {hdr_valid, hdr_skip, cmd_addr, cmd_wdata} = 42'h0;
        repeat (20) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        rd_chk(4'h0, 32'h0000_0000);
        rd_chk(4'h4, 32'h0000_0000);
        wr_reg(4'h4, 32'h0000_0007);
        rd_chk(4'h4, 32'h0000_0007);
        chk(32'(walk), 32'h0000_0000);
        hdr_valid <= 3'b111;
        for (int i = 0; i < 3; i++) begin
            wr_reg(4'h4, 32'h1 << i);
            rd_chk(4'h4, 32'h1 << i);
            chk(32'(walk), 32'h1 << i);
        end
        hdr_valid <= 3'b011;
        hdr_skip <= 3'b010;
        wr_reg(4'h4, 32'h0000_0007);
        rd_chk(4'h4, 32'h0000_0007);
        chk(32'(walk), 32'h0000_0001);
        xfer(1'b1, 24'd16, 2'h1, 1'b0, 1'b1, 4);
        xfer(1'b0, 24'd16, 2'h2, 1'b0, 1'b1, 8);
        xfer(1'b1, 24'd72, 2'h3, 1'b0, 1'b1, 18);
        xfer(1'b1, 24'd6, 2'h0, 1'b0, 1'b1, 2);
        xfer(1'b1, 24'd0, 2'h3, 1'b0, 1'b1, 0);
        xfer(1'b0, 24'd10, 2'h1, 1'b1, 1'b1, 5);
        xfer(1'b1, 24'd12, 2'h2, 1'b1, 1'b1, 3);
        rd_chk(4'hC, RDAT);
        wr_reg(4'h0, 32'h0000_4006);
        xfer(1'b1, 24'd64, 2'h1, 1'b0, 1'b0, 0);
        complete_run();
    end
endmodule
